// file: design/sync_serial_port_consts.svh
// constants for the serial port register slice
`ifndef SYNC_SERIAL_PORT_CONSTS_SVH
`define SYNC_SERIAL_PORT_CONSTS_SVH
// register indices; byte address is four times the index
`define SSP_IDX_BUF      10'h18c
`define SSP_IDX_ADD      10'h18d
`define SSP_IDX_MSK      10'h18e
`define SSP_IDX_STAT     10'h18f
// reset values
`define SSP_RST_BUF      8'h00
`define SSP_RST_ADD      8'h00
`define SSP_RST_MSK      8'hff
`define SSP_RST_STAT     8'h00
// status field positions
`define SSP_STAT_SMP     7
`define SSP_STAT_CKE     6
`define SSP_STAT_DA      5
`define SSP_STAT_P       4
`define SSP_STAT_S       3
`define SSP_STAT_RW      2
`define SSP_STAT_UA      1
`define SSP_STAT_BF      0
// serial clock period is (n + 1) * 4 oscillator periods
`define SSP_CLK_MULT     4
`define SSP_MIN_DIVIDER  8'h03
// ahb transfer type
`define AHB_HTRANS_NSEQ  2'h2
`endif

// file: design/sync_serial_port_pkg.sv
// types shared by the serial port register slice
package sync_serial_port_pkg;
  // operating mode reported by the port control logic
  typedef enum logic [2:0] {
    mode_spi_host     = 3'h0,
    mode_spi_client   = 3'h1,
    mode_i2c_host     = 3'h3,
    mode_i2c_client7  = 3'h2,
    mode_i2c_client10 = 3'h6,
    mode_off          = 3'h4
  } port_mode_t;
  // which 10-bit address byte the client is matching
  typedef enum logic {
    addr_byte_high = 1'b0,
    addr_byte_low  = 1'b1
  } addr_byte_t;
endpackage

// file: design/baud_divider.sv
// serial clock divider producing half-period and full-period pulses
`timescale 1ns/1ns
`include "sync_serial_port_consts.svh"
module baud_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divider,
  output logic                  half_tick,
  output logic                  period_tick
);
  localparam int CW = DIV_W + 2;
  localparam int HALF = `SSP_CLK_MULT / 2;

  logic [CW-1:0] count;
  logic [CW-1:0] half_len;
  logic          phase;

  // half period is (n + 1) * 2 oscillator cycles
  assign half_len = CW'((32'(divider) + 32'd1) * 32'(HALF) - 32'd1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      phase <= 1'b0;
      half_tick <= 1'b0;
      period_tick <= 1'b0;
    end else if (!run) begin
      count <= '0;
      phase <= 1'b0;
      half_tick <= 1'b0;
      period_tick <= 1'b0;
    end else if (count >= half_len) begin
      count <= '0;
      phase <= ~phase;
      half_tick <= 1'b1;
      period_tick <= phase;
    end else begin
      count <= count + CW'(1);
      half_tick <= 1'b0;
      period_tick <= 1'b0;
    end
  end
endmodule

// file: design/sync_serial_port_regs.sv
// register slice of the synchronous serial port with its ahb-lite slave
//
// Overview of operation
// - eight-bit read/write data buffer: writes feed transmit, reads return the last received or written byte
// - host modes: serial clock period is (n + 1) * 4 oscillator periods
// - 10-bit client high byte: register bits 2:1 are address bits 9:8
// - 10-bit client low byte: all eight register bits are address bits 7:0
// - 7-bit client: register bits 7:1 are the address, bit 0 ignored
// - client: set mask bits 7:1 enable compare of that bit; mask resets to ones
// - mask bit 0 applies only in 10-bit client mode
// - spi host: sample-phase 1 samples at end, 0 at middle
// - i2c: sample-phase 1 disables slew control, 0 enables it
// - spi: clock-edge 1 shifts on active-to-idle, 0 on idle-to-active
// - i2c: clock-edge bit enables smbus input thresholds
// - i2c client: data/address flag is 1 after data, 0 after address
// - i2c: stop flag set when stop was the last bus condition
// - i2c: start flag set when start was the last bus condition
// - i2c client: direction bit 1 read, 0 write
// - i2c host: direction bit is 1 while a transmission runs
// - update-address bit driven only in 10-bit client mode
// - update-address bit set when software must reload the own address
// - i2c transmit: buffer-full holds until written byte is sent or the buffer is read
// - receive: buffer-full set on a received byte, cleared by software read
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
`include "sync_serial_port_consts.svh"
module sync_serial_port_regs #(
  parameter int DATA_W = 8
) (
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic [31:0]                           hrdata,
  input  wire sync_serial_port_pkg::port_mode_t mode,
  input  wire logic                             host_busy,
  output logic [DATA_W-1:0]                     tx_byte,
  output logic                                  tx_load,
  input  wire logic                             tx_sent,
  input  wire logic                             rx_valid,
  input  wire logic [DATA_W-1:0]                rx_byte,
  input  wire logic                             byte_done,
  input  wire logic                             byte_was_data,
  input  wire logic                             start_seen,
  input  wire logic                             stop_seen,
  input  wire logic                             addr_match_seen,
  input  wire logic                             rx_rw,
  input  wire sync_serial_port_pkg::addr_byte_t addr_byte_sel,
  input  wire logic [DATA_W-1:0]                rx_addr,
  output logic                                  addr_match,
  input  wire logic                             update_addr_req,
  output logic                                  sclk_half_tick,
  output logic                                  sclk_period_tick,
  output logic                                  sample_at_end,
  output logic                                  shift_active_to_idle,
  output logic                                  slew_ctrl_enable,
  output logic                                  smbus_inputs
);
  import sync_serial_port_pkg::*;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic is_spi;
  logic is_i2c;
  logic is_client;
  logic is_host;

  assign is_spi = (mode == mode_spi_host) || (mode == mode_spi_client);
  assign is_client = (mode == mode_i2c_client7) || (mode == mode_i2c_client10);
  assign is_i2c = is_client || (mode == mode_i2c_host);
  assign is_host = (mode == mode_spi_host) || (mode == mode_i2c_host);

  // ------------------------------------------------------------
  // ahb-lite address phase
  // ------------------------------------------------------------
  logic       req;
  logic [9:0] idx;
  logic       wr_pend;
  logic [9:0] wr_idx;
  logic       hit_buf;
  logic       hit_add;
  logic       hit_msk;
  logic       hit_stat;
  logic       rd_buf;
  logic       wr_buf;
  logic       wr_add;
  logic       wr_msk;
  logic       wr_stat;

  assign req = hsel && hready && (htrans == `AHB_HTRANS_NSEQ);
  assign idx = haddr[11:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 10'h000;
    end else begin
      wr_pend <= req && hwrite;
      wr_idx <= idx;
    end
  end

  // write strobes act in the data phase when hwdata stands
  assign wr_buf = wr_pend && (wr_idx == `SSP_IDX_BUF);
  assign wr_add = wr_pend && (wr_idx == `SSP_IDX_ADD);
  assign wr_msk = wr_pend && (wr_idx == `SSP_IDX_MSK);
  assign wr_stat = wr_pend && (wr_idx == `SSP_IDX_STAT);
  assign hit_buf = (idx == `SSP_IDX_BUF);
  assign hit_add = (idx == `SSP_IDX_ADD);
  assign hit_msk = (idx == `SSP_IDX_MSK);
  assign hit_stat = (idx == `SSP_IDX_STAT);
  assign rd_buf = req && !hwrite && hit_buf;

  // ------------------------------------------------------------
  // data buffer
  // ------------------------------------------------------------
  logic [DATA_W-1:0] data_buf;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_buf <= DATA_W'(`SSP_RST_BUF);
    end else if (rx_valid) begin
      data_buf <= rx_byte;
    end else if (wr_buf) begin
      data_buf <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_byte <= DATA_W'(`SSP_RST_BUF);
      tx_load <= 1'b0;
    end else begin
      tx_load <= wr_buf;
      if (wr_buf) begin
        tx_byte <= hwdata[DATA_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // divider / own address and mask
  // ------------------------------------------------------------
  logic [DATA_W-1:0] own_addr;
  logic [DATA_W-1:0] addr_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_addr <= DATA_W'(`SSP_RST_ADD);
    end else if (wr_add) begin
      own_addr <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_mask <= DATA_W'(`SSP_RST_MSK);
    end else if (wr_msk) begin
      addr_mask <= hwdata[DATA_W-1:0];
    end
  end

  // values below 3 are unsupported in host modes and are used as given
  baud_divider #(
    .DIV_W (DATA_W)
  ) u_baud (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .run         (is_host && host_busy),
    .divider     (own_addr),
    .half_tick   (sclk_half_tick),
    .period_tick (sclk_period_tick)
  );

  // ------------------------------------------------------------
  // address match
  // ------------------------------------------------------------
  logic [DATA_W-1:0] bit_ok;
  logic              match7;
  logic              match_hi;
  logic              match_lo;

  // a bit matches when equal or when its mask bit is clear
  assign bit_ok = ~(rx_addr ^ own_addr) | ~addr_mask;
  assign match7 = &bit_ok[7:1];
  assign match_hi = &bit_ok[2:1];
  assign match_lo = &bit_ok[7:0];

  always_comb begin
    addr_match = 1'b0;
    if (mode == mode_i2c_client7) begin
      addr_match = match7;
    end else if (mode == mode_i2c_client10) begin
      if (addr_byte_sel == addr_byte_high) begin
        addr_match = match_hi;
      end else begin
        addr_match = match_lo;
      end
    end
  end

  // ------------------------------------------------------------
  // status control bits
  // ------------------------------------------------------------
  logic sample_phase_select;
  logic cke;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_phase_select <= 1'(`SSP_RST_STAT >> `SSP_STAT_SMP);
      cke <= 1'(`SSP_RST_STAT >> `SSP_STAT_CKE);
    end else if (wr_stat) begin
      sample_phase_select <= hwdata[`SSP_STAT_SMP];
      cke <= hwdata[`SSP_STAT_CKE];
    end
  end

  // the spi client mode ignores sample phase; software keeps it clear
  assign sample_at_end = (mode == mode_spi_host) && sample_phase_select;
  assign slew_ctrl_enable = is_i2c && !sample_phase_select;
  assign shift_active_to_idle = is_spi && cke;
  assign smbus_inputs = is_i2c && cke;

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  logic da_flag;
  logic stop_flag;
  logic start_flag;
  logic rw_latch;
  logic ua_flag;
  logic bf_flag;
  logic rw_bit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      da_flag <= 1'b0;
    end else if (is_client && byte_done) begin
      da_flag <= byte_was_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_flag <= 1'b0;
      start_flag <= 1'b0;
    end else if (!is_i2c) begin
      stop_flag <= 1'b0;
      start_flag <= 1'b0;
    end else if (stop_seen) begin
      stop_flag <= 1'b1;
      start_flag <= 1'b0;
    end else if (start_seen) begin
      start_flag <= 1'b1;
      stop_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rw_latch <= 1'b0;
    end else if (is_client && addr_match_seen) begin
      rw_latch <= rx_rw;
    end
  end

  always_comb begin
    rw_bit = 1'b0;
    if (is_client) begin
      rw_bit = rw_latch;
    end else if (mode == mode_i2c_host) begin
      rw_bit = host_busy;
    end
  end

  // hardware request wins over the clearing write of a new address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ua_flag <= 1'b0;
    end else if (mode != mode_i2c_client10) begin
      ua_flag <= 1'b0;
    end else if (update_addr_req) begin
      ua_flag <= 1'b1;
    end else if (wr_add) begin
      ua_flag <= 1'b0;
    end
  end

  // set events win over the clearing read or completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bf_flag <= 1'b0;
    end else if (rx_valid) begin
      bf_flag <= 1'b1;
    end else if (wr_buf && is_i2c) begin
      bf_flag <= 1'b1;
    end else if (tx_sent && is_i2c) begin
      bf_flag <= 1'b0;
    end else if (rd_buf) begin
      bf_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [7:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[`SSP_STAT_SMP] = sample_phase_select;
    status_word[`SSP_STAT_CKE] = cke;
    status_word[`SSP_STAT_DA] = is_client && da_flag;
    status_word[`SSP_STAT_P] = stop_flag;
    status_word[`SSP_STAT_S] = start_flag;
    status_word[`SSP_STAT_RW] = rw_bit;
    status_word[`SSP_STAT_UA] = ua_flag;
    status_word[`SSP_STAT_BF] = bf_flag;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (req && !hwrite) begin
      if (hit_buf) begin
        hrdata <= {24'h00_0000, data_buf};
      end else if (hit_add) begin
        hrdata <= {24'h00_0000, own_addr};
      end else if (hit_msk) begin
        hrdata <= {24'h00_0000, addr_mask};
      end else if (hit_stat) begin
        hrdata <= {24'h00_0000, status_word};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// file: dv/serial_engine_model.sv
// model of the serial shift engine facing the register slice
`timescale 1ns/1ns
module serial_engine_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tx_load,
  input  wire logic [7:0] dly,
  output logic            tx_sent
);
  logic       busy;
  logic [7:0] cnt;
  // ----------------------------------------
  // byte send: finishes dly + 1 cycles after load
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy    <= 1'b0;
      cnt     <= 8'h00;
      tx_sent <= 1'b0;
    end else begin
      tx_sent <= 1'b0;
      if (tx_load) begin
        busy <= 1'b1;
        cnt  <= dly;
      end else if (busy && cnt == 8'h00) begin
        busy    <= 1'b0;
        tx_sent <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// file: dv/serial_port_regs_assertions.sv
// concurrent checks on the serial port register slice ports
`timescale 1ns/1ns
`include "sync_serial_port_consts.svh"
module serial_port_regs_checker
  import sync_serial_port_pkg::*;
(
  input wire logic                             hclk,
  input wire logic                             hresetn,
  input wire logic                             hsel,
  input wire logic [31:0]                      haddr,
  input wire logic [1:0]                       htrans,
  input wire logic                             hwrite,
  input wire logic [31:0]                      hwdata,
  input wire logic                             hready,
  input wire logic [31:0]                      hrdata,
  input wire sync_serial_port_pkg::port_mode_t mode,
  input wire logic                             host_busy,
  input wire logic [7:0]                       tx_byte,
  input wire logic                             tx_load,
  input wire sync_serial_port_pkg::addr_byte_t addr_byte_sel,
  input wire logic [7:0]                       rx_addr,
  input wire logic                             addr_match,
  input wire logic                             sclk_half_tick,
  input wire logic                             sclk_period_tick,
  input wire logic                             sample_at_end,
  input wire logic                             shift_active_to_idle,
  input wire logic                             slew_ctrl_enable,
  input wire logic                             smbus_inputs
);
  logic        tk;
  logic        wp;
  logic [9:0]  wi;
  logic [7:0]  add;
  logic [7:0]  msk;
  logic [7:0]  st;
  logic [10:0] gap;
  logic        seen;
  assign tk = hsel && hready && htrans == 2'h2;
  // ----------------------------------------
  // shadow of the writable address, mask and status registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp  <= 1'b0;
      wi  <= 10'h000;
      add <= 8'h00;
      msk <= 8'hff;
      st  <= 8'h00;
    end else begin
      wp <= tk && hwrite;
      if (tk) begin
        wi <= haddr[11:2];
      end
      if (wp && wi == `SSP_IDX_ADD) add <= hwdata[7:0];
      if (wp && wi == `SSP_IDX_MSK) msk <= hwdata[7:0];
      if (wp && wi == `SSP_IDX_STAT) st <= {hwdata[7:6], 6'h00};
    end
  end
  // cycles since the last serial clock period tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap  <= 11'h000;
      seen <= 1'b0;
    end else if (!host_busy) begin
      gap  <= 11'h000;
      seen <= 1'b0;
    end else if (sclk_period_tick) begin
      gap  <= 11'h000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 11'h001;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  buf_load_a: assert property (tk && hwrite && haddr[11:2] == `SSP_IDX_BUF
    |=> ##1 tx_load && tx_byte == $past(hwdata[7:0])) else $error("buffer load wrong");
  load_cause_a: assert property (tx_load
    |-> $past(wp) && $past(wi) == `SSP_IDX_BUF) else $error("stray buffer load");
  reg_read_a: assert property (tk && !hwrite && haddr[11:2] inside {`SSP_IDX_ADD, `SSP_IDX_MSK}
    |=> hrdata == {24'h0, wi == `SSP_IDX_ADD ? add : msk}) else $error("register read wrong");
  stat_cfg_a: assert property (tk && !hwrite && haddr[11:2] == `SSP_IDX_STAT
    |=> hrdata[7:6] == st[7:6] && hrdata[31:8] == 24'h0) else $error("status config wrong");
  match7_a: assert property (mode == mode_i2c_client7
    |-> addr_match == (((rx_addr ^ add) & msk & 8'hfe) == 8'h00)) else $error("7-bit match wrong");
  match10_a: assert property (mode == mode_i2c_client10 && addr_byte_sel == addr_byte_low
    |-> addr_match == (((rx_addr ^ add) & msk) == 8'h00)) else $error("low byte match wrong");
  no_match_a: assert property (mode inside {mode_spi_host, mode_spi_client, mode_i2c_host}
    |-> !addr_match) else $error("match outside client");
  spi_cfg_a: assert property (mode == mode_spi_host
    |-> sample_at_end == st[7] && shift_active_to_idle == st[6]) else $error("spi config wrong");
  i2c_cfg_a: assert property (mode inside {mode_i2c_host, mode_i2c_client7}
    |-> slew_ctrl_enable == !st[7] && smbus_inputs == st[6]) else $error("i2c config wrong");
  sclk_period_a: assert property (sclk_period_tick && seen
    |-> gap == {1'b0, add, 2'b00} + 11'h003) else $error("serial clock period wrong");
  tick_idle_a: assert property (!host_busy [*2] |-> !sclk_half_tick)
    else $error("tick while idle");
  cover property (sclk_period_tick && seen);
  cover property (addr_match);
  cover property (tx_load);
endmodule

bind sync_serial_port_regs serial_port_regs_checker u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .mode,
  .host_busy, .tx_byte, .tx_load, .addr_byte_sel, .rx_addr, .addr_match, .sclk_half_tick,
  .sclk_period_tick, .sample_at_end, .shift_active_to_idle, .slew_ctrl_enable, .smbus_inputs
);

// file: dv/serial_port_data_address_status_regs_tb_top.sv
// self-checking bench for the serial port register slice
`timescale 1ns/1ns
`include "sync_serial_port_consts.svh"
module serial_port_data_address_status_regs_tb_top;
  import sync_serial_port_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, host_busy;
  logic        tx_load, tx_sent, rx_valid, byte_done, byte_was_data, start_seen;
  logic        stop_seen, addr_match_seen, rx_rw, addr_match, update_addr_req;
  logic        sclk_period_tick;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  tx_byte, rx_byte, rx_addr, dly;
  port_mode_t  mode;
  addr_byte_t  addr_byte_sel;
  int          miscompares, compares, n;
  assign hready = hreadyout;
  sync_serial_port_regs DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .mode, .host_busy, .tx_byte, .tx_load, .tx_sent, .rx_valid, .rx_byte,
    .byte_done, .byte_was_data, .start_seen, .stop_seen, .addr_match_seen, .rx_rw,
    .addr_byte_sel, .rx_addr, .addr_match, .update_addr_req, .sclk_half_tick(),
    .sclk_period_tick, .sample_at_end(), .shift_active_to_idle(), .slew_ctrl_enable(),
    .smbus_inputs()
  );
  serial_engine_model u_eng (.hclk, .hresetn, .tx_load, .dly, .tx_sent);
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d,
                      output logic [7:0] q);
    haddr  <= {20'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, i, d, q);
  endtask
  task automatic rdc(input string nm, input logic [9:0] i, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, i, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic mchk(input logic [7:0] a, input logic e);
    rx_addr <= a;
    @(negedge hclk);
    chk("match", {7'h0, e}, {7'h0, addr_match});
    @(posedge hclk);
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    complete_run();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {hresetn, hwrite, host_busy, rx_valid, byte_done, byte_was_data} = 6'h00;
    {start_seen, stop_seen, addr_match_seen, rx_rw, update_addr_req} = 5'h00;
    {htrans, haddr, hwdata, rx_byte, rx_addr} = '0;
    {hsel, hsize, dly} = {1'b1, 3'h2, 8'h14};
    mode = mode_i2c_host;
    addr_byte_sel = addr_byte_high;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("divider", `SSP_IDX_ADD, 8'h00);
    rdc("mask", `SSP_IDX_MSK, 8'hff);
    rdc("status", `SSP_IDX_STAT, 8'h00);
    rdc("unmapped", 10'h190, 8'h00);
    wr(`SSP_IDX_ADD, 8'h03);
    rdc("divider", `SSP_IDX_ADD, 8'h03);
    wr(`SSP_IDX_STAT, 8'hff);
    rdc("status", `SSP_IDX_STAT, 8'hc0);
    host_busy <= 1'b1;
    wr(`SSP_IDX_BUF, 8'h3c);
    rdc("status", `SSP_IDX_STAT, 8'hc5);
    repeat (30) @(posedge hclk);
    rdc("status", `SSP_IDX_STAT, 8'hc4);
    host_busy <= 1'b0;
    rdc("status", `SSP_IDX_STAT, 8'hc0);
    mode <= mode_spi_host;
    host_busy <= 1'b1;
    n = 0;
    do @(negedge hclk); while (sclk_period_tick !== 1'b1 && ++n < 200);
    n = 0;
    do @(negedge hclk); while (sclk_period_tick !== 1'b1 && ++n < 200);
    // n counts the cycles strictly between two period ticks
    chk("period", 8'((8'h03 + 8'h01) * `SSP_CLK_MULT - 1), n[7:0]);
    @(posedge hclk);
    host_busy <= 1'b0;
    rx_byte <= 8'ha5;
    rx_valid <= 1'b1;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rdc("status", `SSP_IDX_STAT, 8'hc1);
    rdc("buffer", `SSP_IDX_BUF, 8'ha5);
    rdc("status", `SSP_IDX_STAT, 8'hc0);
    mode <= mode_i2c_client7;
    wr(`SSP_IDX_ADD, 8'h54);
    mchk(8'h55, 1'b1);
    mchk(8'h56, 1'b0);
    wr(`SSP_IDX_MSK, 8'hfd);
    mchk(8'h56, 1'b1);
    {rx_rw, addr_match_seen, byte_done, byte_was_data, start_seen} <= 5'h1f;
    @(posedge hclk);
    {addr_match_seen, byte_done, start_seen} <= 3'h0;
    rdc("status", `SSP_IDX_STAT, 8'hec);
    stop_seen <= 1'b1;
    @(posedge hclk);
    stop_seen <= 1'b0;
    rdc("status", `SSP_IDX_STAT, 8'hf4);
    mode <= mode_i2c_client10;
    wr(`SSP_IDX_MSK, 8'hff);
    wr(`SSP_IDX_ADD, 8'h06);
    mchk(8'hf7, 1'b1);
    mchk(8'hf4, 1'b0);
    addr_byte_sel <= addr_byte_low;
    wr(`SSP_IDX_ADD, 8'h3c);
    mchk(8'h3d, 1'b0);
    wr(`SSP_IDX_MSK, 8'hfe);
    mchk(8'h3d, 1'b1);
    update_addr_req <= 1'b1;
    @(posedge hclk);
    update_addr_req <= 1'b0;
    rdc("status", `SSP_IDX_STAT, 8'hf6);
    mode <= mode_i2c_client7;
    // update-address clears one edge after the mode leaves 10-bit client
    @(posedge hclk);
    rdc("status", `SSP_IDX_STAT, 8'hf4);
    mode <= mode_spi_client;
    wr(`SSP_IDX_STAT, 8'h40);
    rdc("status", `SSP_IDX_STAT, 8'h40);
    complete_run();
  end
endmodule
